/* hdl/acs_link_shift.sv */
/*
  acs_link_shift: serial engine on the link clock. Shifts the control or
  mask word in and the result word out, one bit per falling clock edge.
  Assumes tx_word stays stable for a whole frame and frame sync is high
  between frames; the link clock may stop outside frames.
*/
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_link_shift
(
  // link pins
  input wire logic conv_serial_clock,
  input wire logic conv_frame_sync_n,
  input wire logic conv_serial_in,
  output logic conv_serial_out,
  output logic conv_serial_out_oe,
  // reset
  input wire logic rst_n,
  // core side, held words and event toggles
  input wire logic [15:0] tx_word,
  output logic [`ACS_CTRL_BITS-1:0] ctrl_hold,
  output logic [15:0] mask_hold,
  output logic mux_tgl,
  output logic done_tgl
);
  import acs_pkg::*;

  logic clr_n; // frame sync high clears the bit counter
  logic [4:0] cnt_r; // falling edges seen in this frame
  logic [15:0] rx_r; // receive shifter
  logic [15:0] rx_nxt; // shifter after this edge
  logic [3:0] out_idx; // bit of tx_word on the pin
  logic in_frame; // counter still below frame length

  //////////////////////////////////////////////////////////////////////////
  // decode
  // clear is asynchronous because the clock may be stopped between frames
  assign clr_n = rst_n & ~conv_frame_sync_n;
  assign rx_nxt = {rx_r[14:0], conv_serial_in};
  assign in_frame = cnt_r < `ACS_FRAME_BITS;
  assign out_idx = 4'(4'hF - cnt_r[3:0]);
  // RULE_21 address first
  assign conv_serial_out = in_frame ? tx_word[out_idx] : 1'b0;
  assign conv_serial_out_oe = ~conv_frame_sync_n & in_frame;

  //////////////////////////////////////////////////////////////////////////
  // bit counter and receive shifter
  always_ff @(negedge conv_serial_clock or negedge clr_n)
  begin
    if (!clr_n)
    begin
      cnt_r <= 5'h00;
      rx_r <= 16'h0000;
    end
    else if (in_frame)
    begin
      cnt_r <= 5'(cnt_r + 5'h01);
      rx_r <= rx_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // held words and toggles, kept across frames
  always_ff @(negedge conv_serial_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_hold <= `ACS_CTRL_RST;
      mask_hold <= `ACS_MASK_RST;
      mux_tgl <= 1'b0;
      done_tgl <= 1'b0;
    end
    // RULE_20 fourteenth edge
    else if (!conv_frame_sync_n && cnt_r == 5'(`ACS_MUX_EDGE - 5'h01))
    begin
      ctrl_hold <= rx_nxt[13:2];
      mux_tgl <= ~mux_tgl;
    end
    // RULE_11 sixteenth edge
    else if (!conv_frame_sync_n && cnt_r == 5'(`ACS_FRAME_BITS - 5'h01))
    begin
      mask_hold <= rx_nxt;
      done_tgl <= ~done_tgl;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks on the link clock
  // RULE_20 mux event timing
  chk_mux_edge_toggle: assert property (@(negedge conv_serial_clock) disable iff (!clr_n)
    cnt_r == 5'h0D |=> mux_tgl != $past(mux_tgl) && cnt_r == 5'h0E)
    else $error("mux event missed on edge 14");
  // RULE_21 address leads the result
  chk_result_first_bit: assert property (@(negedge conv_serial_clock) disable iff (!clr_n)
    cnt_r == 5'h00 |-> conv_serial_out == tx_word[15] && conv_serial_out_oe)
    else $error("result frame does not open with address bit 3");
endmodule // acs_link_shift

/* hdl/acs_seq_ctrl.sv */
/*
  acs_seq_ctrl: control logic of a 16-channel converter: channel decode,
  power modes, sequencer modes and the write-only channel mask.
  Assumes the host frames transfers with a falling frame sync and 16 falling
  link clock edges, and that the analog side hands a 12-bit result per frame.
*/
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_seq_ctrl
(
  // system clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link pins
  input wire logic conv_serial_clock,
  input wire logic conv_frame_sync_n,
  input wire logic conv_serial_in,
  output logic conv_serial_out,
  output logic conv_serial_out_oe,
  // analog side
  input wire logic [11:0] conv_result,
  output logic [15:0] analog_input_select,
  output acs_pkg::acs_cfg_t conv_cfg,
  output logic adc_power_on,
  output logic adc_bias_on,
  output logic adc_ready,
  // status
  output acs_pkg::acs_seq_mode_t seq_mode
);
  import acs_pkg::*;

  localparam int WAKE_D = `ACS_WAKE_CYC; // cycles from wake to ready

  // link side words and toggles
  logic [11:0] ctrl_hold; // control word, stable after edge 14
  logic [15:0] mask_hold; // full word, stable after edge 16
  logic mux_tgl; // flips on edge 14
  logic done_tgl; // flips on edge 16
  // crossing flops: stage one is read only by stage two
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r; // previous stage two, for edge detect
  logic mux_ev; // one pulse per edge 14
  logic done_ev; // one pulse per edge 16
  logic frame_start; // frame sync fell
  // control and sequencer state
  acs_ctrl_t ctrl_r;
  acs_ctrl_t word_in; // control word just received
  acs_seq_mode_t mode_r;
  acs_seq_mode_t mode_nxt;
  logic mask_pend_r; // next transfer carries the mask
  logic mask_take_r; // mask transfer has passed edge 14
  logic mask_load; // mask word complete, load it now
  logic [15:0] mask_r; // channel mask, bit i is channel i
  logic [15:0] mask_rev; // received word in channel order
  logic [3:0] mux_chan_r; // channel on the multiplexer
  logic [3:0] mux_chan_nxt;
  logic [3:0] conv_chan_r; // channel whose result goes out next
  logic [15:0] tx_word_r; // address and result for the next frame
  logic ctl_wr; // valid control write this frame
  logic [1:0] seq_sel; // sequence and shadow bits of word_in
  // power state
  acs_pwr_t pwr_st_r;
  acs_pwr_t pwr_nxt;
  logic [4:0] wake_cnt_r;
  logic wake_done;
  logic auto_pm; // one of the two automatic modes

  //////////////////////////////////////////////////////////////////////////
  // link engine on its own clock
  acs_link_shift u_link
  (
    .conv_serial_clock(conv_serial_clock),
    .conv_frame_sync_n(conv_frame_sync_n),
    .conv_serial_in(conv_serial_in),
    .conv_serial_out(conv_serial_out),
    .conv_serial_out_oe(conv_serial_out_oe),
    .rst_n(rst_n),
    .tx_word(tx_word_r),
    .ctrl_hold(ctrl_hold),
    .mask_hold(mask_hold),
    .mux_tgl(mux_tgl),
    .done_tgl(done_tgl)
  );

  //////////////////////////////////////////////////////////////////////////
  // two-flop crossing of toggles and the frame sync pin
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 3'h4;
      sync2_r <= 3'h4;
      sync3_r <= 3'h4;
    end
    else
    begin
      sync1_r <= {conv_frame_sync_n, done_tgl, mux_tgl};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // held words are read only after their toggle has crossed, so stable
  assign mux_ev = sync2_r[0] ^ sync3_r[0];
  assign done_ev = sync2_r[1] ^ sync3_r[1];
  assign frame_start = sync3_r[2] & ~sync2_r[2];

  //////////////////////////////////////////////////////////////////////////
  // control word decode
  assign word_in = acs_ctrl_t'(ctrl_hold);
  assign seq_sel = {word_in.sequence_bit, word_in.shadow};
  // RULE_18 write bit gates update
  // RULE_08 mask transfer is not a control word
  assign ctl_wr = mux_ev & ~mask_pend_r & word_in.write;
  // RULE_12 load only at the end of the transfer after the 01 write
  assign mask_load = done_ev & mask_take_r;

  // next set mask bit after cur, wrapping; cur itself if alone
  function automatic logic [3:0] next_masked(input logic [15:0] m, input logic [3:0] cur);
    logic [3:0] res;
    logic found;
    logic [3:0] idx;
    res = cur;
    found = 1'b0;
    for (int k = 1; k <= 16; k++)
    begin
      idx = 4'(cur + 4'(k));
      if (!found && m[idx])
      begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // per channel: mask reversal and multiplexer decode
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_chan
      // RULE_13 first bit is channel 0
      assign mask_rev[gi] = mask_hold[15 - gi];
      // RULE_01 binary channel decode
      assign analog_input_select[gi] = mux_chan_r == 4'(gi);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb
  begin
    mode_nxt = mode_r;
    if (mask_load)
      mode_nxt = SEQ_MASK;
    else if (ctl_wr)
    begin
      // RULE_16 any write but 10 ends sequencing
      unique case (seq_sel)
        2'b00: mode_nxt = SEQ_IDLE;
        2'b01: mode_nxt = SEQ_IDLE;
        // RULE_09 sequence keeps running
        2'b10: mode_nxt = mode_r;
        2'b11: mode_nxt = SEQ_CONSEC;
      endcase
    end
  end

  // channel for the next conversion, switched with the edge 14 event, or with the edge 16 event on a mask load
  always_comb
  begin
    mux_chan_nxt = mux_chan_r;
    if (mask_load)
      // RULE_15 start at lowest masked
      mux_chan_nxt = next_masked(mask_rev, 4'hF);
    else if (ctl_wr && seq_sel == 2'b11)
      // RULE_10 consecutive from channel 0
      mux_chan_nxt = 4'h0;
    else if (ctl_wr && !word_in.sequence_bit)
      // RULE_07 RULE_19 written address
      mux_chan_nxt = word_in.chan_addr;
    else if (mux_ev && mode_r == SEQ_CONSEC)
      mux_chan_nxt = (mux_chan_r == ctrl_r.chan_addr) ? 4'h0 : 4'(mux_chan_r + 4'h1);
    else if (mux_ev && mode_r == SEQ_MASK)
      // RULE_14 RULE_15 ascend and wrap
      mux_chan_nxt = next_masked(mask_r, mux_chan_r);
  end

  //////////////////////////////////////////////////////////////////////////
  // control, sequencer and mask registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    // RULE_22 idle and empty mask
    if (!rst_n)
    begin
      ctrl_r <= `ACS_CTRL_RST;
      mode_r <= SEQ_IDLE;
      mask_pend_r <= 1'b0;
      mask_take_r <= 1'b0;
      mask_r <= `ACS_MASK_RST;
      mux_chan_r <= 4'h0;
    end
    else
    begin
      if (ctl_wr)
        ctrl_r <= word_in;
      mode_r <= mode_nxt;
      mux_chan_r <= mux_chan_nxt;
      // RULE_12 arm only on a 01 write
      if (ctl_wr)
        mask_pend_r <= seq_sel == 2'b01;
      else if (mask_load)
        mask_pend_r <= 1'b0;
      // the arming transfer ends too, so wait for the next edge 14 first
      if (mux_ev && mask_pend_r)
        mask_take_r <= 1'b1;
      else if (mask_load)
        mask_take_r <= 1'b0;
      // RULE_11 RULE_12 load mask
      if (mask_load)
        mask_r <= mask_rev;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // result word for the next frame
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_chan_r <= 4'h0;
      tx_word_r <= 16'h0000;
    end
    else
    begin
      if (mux_ev)
        conv_chan_r <= mux_chan_r;
      // RULE_21 address ahead of data
      if (done_ev)
        tx_word_r <= {conv_chan_r, conv_result};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power state
  assign auto_pm = ctrl_r.power_mode == PM_AUTO_SD || ctrl_r.power_mode == PM_STANDBY;
  assign wake_done = wake_cnt_r == 5'(WAKE_D - 1);

  always_comb
  begin
    pwr_nxt = pwr_st_r;
    unique case (pwr_st_r)
      PWR_OFF: if ((auto_pm && frame_start) || ctrl_r.power_mode == PM_NORMAL)
        pwr_nxt = PWR_WAKE;
      // RULE_04 RULE_06 one microsecond wake
      PWR_WAKE: if (wake_done)
        pwr_nxt = PWR_ON;
      // RULE_04 sleep after conversion
      PWR_ON: if (auto_pm && done_ev)
        pwr_nxt = PWR_OFF;
      default: pwr_nxt = PWR_OFF;
    endcase
    // RULE_03 full shutdown wins
    if (ctrl_r.power_mode == PM_FULL_DOWN)
      pwr_nxt = PWR_OFF;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_st_r <= PWR_OFF;
      wake_cnt_r <= 5'h00;
    end
    else
    begin
      pwr_st_r <= pwr_nxt;
      wake_cnt_r <= (pwr_st_r == PWR_WAKE) ? 5'(wake_cnt_r + 5'h01) : 5'h00;
    end
  end

  // RULE_02 RULE_06 power outputs
  assign adc_power_on = pwr_st_r != PWR_OFF;
  assign adc_bias_on = adc_power_on || ctrl_r.power_mode == PM_STANDBY;
  assign adc_ready = pwr_st_r == PWR_ON;
  assign conv_cfg = '{weak_drive: ctrl_r.weak_drive, range_sel: ctrl_r.range_sel,
    coding: ctrl_r.coding};
  assign seq_mode = mode_r;

  //////////////////////////////////////////////////////////////////////////
  // checks on the system clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_chan_decode: assert property ($onehot(analog_input_select) // RULE_01
    && analog_input_select[mux_chan_r])
    else $error("channel select not one-hot on the addressed input");
  chk_normal_stays: assert property (ctrl_r.power_mode == PM_NORMAL && adc_ready // RULE_02
    |=> adc_ready)
    else $error("normal mode dropped power");
  chk_full_down: assert property ($past(ctrl_r.power_mode) == PM_FULL_DOWN // RULE_03
    && ctrl_r.power_mode == PM_FULL_DOWN |-> !adc_power_on && !adc_bias_on)
    else $error("full shutdown left circuits powered");
  chk_wake_time: assert property ($rose(pwr_st_r == PWR_WAKE) // RULE_04
    |-> !adc_ready ##WAKE_D adc_ready)
    else $error("wake did not take one microsecond");
  chk_auto_sleep: assert property (auto_pm && adc_ready && done_ev |=> !adc_power_on) // RULE_04
    else $error("automatic mode stayed on after conversion");
  chk_standby_bias: assert property (ctrl_r.power_mode == PM_STANDBY |-> adc_bias_on) // RULE_06
    else $error("standby lost the bias generator");
  chk_plain_write: assert property (ctl_wr && seq_sel == 2'b00 // RULE_07
    |=> mode_r == SEQ_IDLE && mux_chan_r == $past(word_in.chan_addr))
    else $error("plain write did not select its channel");
  chk_mask_arm: assert property (mux_ev && mask_pend_r |=> mask_take_r) // RULE_08
    else $error("mask transfer taken as control word");
  chk_seq_keep: assert property (ctl_wr && seq_sel == 2'b10 |=> mode_r == $past(mode_r)) // RULE_09
    else $error("write 10 disturbed the sequence");
  chk_consec_wrap: assert property (mode_r == SEQ_CONSEC && mux_ev && !ctl_wr // RULE_10
    && mux_chan_r == ctrl_r.chan_addr |=> mux_chan_r == 4'h0)
    else $error("consecutive sequence did not wrap to 0");
  chk_mask_hold: assert property (!mask_load |=> $stable(mask_r)) // RULE_12
    else $error("mask changed without a pending load");
  chk_mask_step: assert property (mode_r == SEQ_MASK && mux_ev && !ctl_wr // RULE_15
    && mask_r != 16'h0000 |=> mask_r[mux_chan_r])
    else $error("sequence stepped onto an unmasked channel");
  chk_ctrl_gate: assert property (mux_ev && !ctl_wr |=> $stable(ctrl_r)) // RULE_18
    else $error("control changed without write bit");

  cov_mask_mode: cover property (mask_load ##1 mode_r == SEQ_MASK);
  cov_consec_wrap: cover property (mode_r == SEQ_CONSEC && mux_ev
    && mux_chan_r == ctrl_r.chan_addr);
  cov_auto_wake: cover property (auto_pm && $rose(adc_ready));
  cov_full_down: cover property (ctrl_r.power_mode == PM_FULL_DOWN && !adc_power_on);
endmodule // acs_seq_ctrl

/* inc/acs_consts.svh */
/*
  acs_consts.svh: offsets, field positions, reset values and timing counts
  of the converter channel sequencer control.
  Assumes the system clock runs at 25 MHz and the serial link at up to 33 MHz.
*/
// Contract
// RULE_01 - address value n selects input n
// RULE_02 - mode 11 keeps converter fully powered
// RULE_03 - mode 10 full power down, config kept
// RULE_04 - mode 01 sleeps after conversion, 1 us wake
// RULE_05 - host waits 1 us before trusting result
// RULE_06 - mode 00 standby, bias kept, 1 us ready
// RULE_07 - sequence 00 uses last written address
// RULE_08 - sequence 01 makes next transfer mask data
// RULE_09 - sequence 10 updates fields, sequence continues
// RULE_10 - sequence 11 runs channel 0 to final
// RULE_11 - 16-bit mask shifted in during readout
// RULE_12 - mask loads only after a 01 write
// RULE_13 - first mask bit is channel 0
// RULE_14 - each set bit adds its channel
// RULE_15 - masked channels ascend, one per frame, wrap
// RULE_16 - sequencing ends on any write except 10
// RULE_17 - host leaves sequences by writing 00
// RULE_18 - control updates only when write bit set
// RULE_19 - address bits 9:6 apply at sequence end
// RULE_20 - multiplexer switches on 14th falling edge
// RULE_21 - result carries address ahead of data
// RULE_22 - reset leaves sequencing idle, mask cleared
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// serial frame layout
`define ACS_FRAME_BITS 5'h10
`define ACS_MUX_EDGE 5'h0E
`define ACS_CTRL_BITS 12

// control word field positions
`define ACS_F_WRITE 11
`define ACS_F_SEQ 10
`define ACS_F_ADDR_HI 9
`define ACS_F_ADDR_LO 6
`define ACS_F_SHADOW 3

// reset values: normal power, no sequencing, empty mask
`define ACS_CTRL_RST 12'h030
`define ACS_MASK_RST 16'h0000

// timing: clock rate and wake time from power down
`define ACS_CLK_MHZ 25
`define ACS_WAKE_NS 1000
`define ACS_WAKE_CYC ((`ACS_WAKE_NS * `ACS_CLK_MHZ + 999) / 1000)

`endif

/* inc/acs_pkg.sv */
/*
  acs_pkg: types of the converter channel sequencer control.
  Assumes acs_consts.svh holds every number.
*/
package acs_pkg;

  // sequencer state, gray along idle -> consecutive -> masked
  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_CONSEC = 2'b01,
    SEQ_MASK = 2'b11
  } acs_seq_mode_t;

  // power mode field encoding
  typedef enum logic [1:0]
  {
    PM_STANDBY = 2'b00,
    PM_AUTO_SD = 2'b01,
    PM_FULL_DOWN = 2'b10,
    PM_NORMAL = 2'b11
  } acs_pm_t;

  // converter power state, gray along off -> wake -> on
  typedef enum logic [1:0]
  {
    PWR_OFF = 2'b00,
    PWR_WAKE = 2'b01,
    PWR_ON = 2'b11
  } acs_pwr_t;

  // 12-bit control word, first bit received is write
  typedef struct packed
  {
    logic write;
    logic sequence_bit;
    logic [3:0] chan_addr;
    acs_pm_t power_mode;
    logic shadow;
    logic weak_drive;
    logic range_sel;
    logic coding;
  } acs_ctrl_t;

  // conversion settings handed to the analog side
  typedef struct packed
  {
    logic weak_drive;
    logic range_sel;
    logic coding;
  } acs_cfg_t;

endpackage

/* testbench/acs_host_model.sv */
/*
  acs_host_model: host side of the converter serial link. Frames a 16-bit
  transfer, shifts a word in and collects the result word.
  Assumes the device shifts on falling link edges and drives out from fs fall.
*/
`timescale 1ns/1ps

module acs_host_model
#(
  parameter int HALF_NS = 15,
  parameter int GAP_NS = 400
)
(
  // link pins
  output logic conv_serial_clock,
  output logic conv_frame_sync_n,
  output logic conv_serial_in,
  input wire logic conv_serial_out
);
  // idle: clock parked high, frame sync high
  initial
  begin
    conv_serial_clock = 1'b1;
    conv_frame_sync_n = 1'b1;
    conv_serial_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one framed transfer; lead stretches the gap before the first edge
  task automatic xfer(input logic [15:0] din, input int lead_ns, output logic [15:0] dout);
    int i;
    begin
      conv_frame_sync_n = 1'b0;
      conv_serial_in = din[15];
      #(lead_ns);
      for (i = 15; i >= 0; i--)
      begin
        #(HALF_NS);
        // sample while high, bit settled since last fall
        dout[i] = conv_serial_out;
        conv_serial_clock = 1'b0;
        #(HALF_NS);
        // past last bit: show the inverse, never a stale level
        conv_serial_in = (i > 0) ? din[i-1] : ~din[0];
        conv_serial_clock = 1'b1;
      end
      #(HALF_NS);
      conv_frame_sync_n = 1'b1;
      // gap lets the device update its result word
      #(GAP_NS);
    end
  endtask
endmodule // acs_host_model

/* testbench/tb_top.sv */
/*
  tb_top: self-checking bench of the channel sequencer control.
  Assumes acs_host_model drives the link and the bench feeds results.
*/
`timescale 1ns/1ps
`include "acs_consts.svh"

`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("ERROR t=%0t got %0h exp %0h", $time, (got), (exp)); \
    end \
  end

module tb_top;
  import acs_pkg::*;
  // clock, reset and pins
  logic clk;
  logic rst_n;
  logic conv_serial_clock;
  logic conv_frame_sync_n;
  logic conv_serial_in;
  logic conv_serial_out;
  logic conv_serial_out_oe;
  logic [11:0] conv_result;
  logic [15:0] analog_input_select;
  acs_cfg_t conv_cfg;
  logic adc_power_on;
  logic adc_bias_on;
  logic adc_ready;
  acs_seq_mode_t seq_mode;
  // bookkeeping
  int fail_count = 0;
  int n_tests = 0;
  logic [3:0] cur_ch;
  logic cur_ok;
  logic [15:0] pend;
  logic pend_ok;
  logic [11:0] res_n;
  int k;
  int msk_seq [4] = '{5, 9, 2, 5};

  acs_seq_ctrl i_dut
  (
    .clk(clk),
    .rst_n(rst_n),
    .conv_serial_clock(conv_serial_clock),
    .conv_frame_sync_n(conv_frame_sync_n),
    .conv_serial_in(conv_serial_in),
    .conv_serial_out(conv_serial_out),
    .conv_serial_out_oe(conv_serial_out_oe),
    .conv_result(conv_result),
    .analog_input_select(analog_input_select),
    .conv_cfg(conv_cfg),
    .adc_power_on(adc_power_on),
    .adc_bias_on(adc_bias_on),
    .adc_ready(adc_ready),
    .seq_mode(seq_mode)
  );

  acs_host_model i_host
  (
    .conv_serial_clock(conv_serial_clock),
    .conv_frame_sync_n(conv_frame_sync_n),
    .conv_serial_in(conv_serial_in),
    .conv_serial_out(conv_serial_out)
  );

  // 25 MHz system clock
  always #20 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // control word: write, seq, address, power mode, shadow, low three bits
  function automatic logic [15:0] cw(logic wr, logic sq, logic [3:0] ad, logic [1:0] pm,
                                     logic sh, logic [2:0] lo);
    return {wr, sq, ad, pm, sh, lo, 4'h0};
  endfunction

  // one transfer; ch_after below zero means the channel is not predicted
  task automatic frame(input logic [15:0] din, input int ch_after, input int lead);
    logic [15:0] dout;
    begin
      @(posedge clk);
      conv_result <= res_n;
      @(posedge clk);
      i_host.xfer(din, lead, dout);
      if (pend_ok) `CHK(dout, pend)
      `CHK(conv_serial_out_oe, 1'b0)
      // result of this frame leaves in the next one
      pend = {cur_ch, res_n};
      pend_ok = cur_ok;
      cur_ok = (ch_after >= 0);
      if (ch_after >= 0)
      begin
        `CHK(analog_input_select, 16'h0001 << ch_after)
        cur_ch = ch_after[3:0];
      end
      res_n = res_n + 12'h111;
    end
  endtask

  // verdict, reached from the main sequence or the watchdog
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the 39 frames of the run
  initial
  begin
    #(500_000);
    fail_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    test_done();
  end

  // main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    conv_result = 12'h000;
    cur_ch = 4'h0;
    cur_ok = 1'b1;
    pend = 16'h0000;
    pend_ok = 1'b0;
    res_n = 12'hA5C;
    repeat (3) @(posedge clk);
    `CHK(seq_mode, SEQ_IDLE)
    `CHK(analog_input_select, 16'h0001)
    `CHK(adc_power_on, 1'b0)
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (35) @(posedge clk);
    `CHK(adc_ready, 1'b1)
    // single channel: every address value
    for (k = 0; k < 16; k++)
      frame(cw(1'b1, 1'b0, k[3:0], 2'b11, 1'b0, 3'h0), k, 60);
    frame(cw(1'b0, 1'b0, 4'h5, 2'b11, 1'b0, 3'h0), 15, 60);
    // consecutive run up to channel 3, then wrap
    frame(cw(1'b1, 1'b1, 4'h3, 2'b11, 1'b1, 3'h0), 0, 60);
    `CHK(seq_mode, SEQ_CONSEC)
    for (k = 1; k < 6; k++)
      frame(16'h0000, k % 4, 60);
    // field update keeps the run going
    frame(cw(1'b1, 1'b1, 4'h3, 2'b11, 1'b0, 3'h5), 2, 60);
    `CHK(seq_mode, SEQ_CONSEC)
    `CHK(conv_cfg, acs_cfg_t'(3'h5))
    frame(cw(1'b1, 1'b0, 4'h7, 2'b11, 1'b0, 3'h0), 7, 60);
    `CHK(seq_mode, SEQ_IDLE)
    // mask armed, then channels 2, 5 and 9 loaded
    frame(cw(1'b1, 1'b0, 4'h7, 2'b11, 1'b1, 3'h0), 7, 60);
    frame(16'h2440, 2, 60);
    `CHK(seq_mode, SEQ_MASK)
    for (k = 0; k < 4; k++)
      frame(16'h0000, msk_seq[k], 60);
    // a consecutive write also ends masked running
    frame(cw(1'b1, 1'b1, 4'h2, 2'b11, 1'b1, 3'h0), 0, 60);
    `CHK(seq_mode, SEQ_CONSEC)
    frame(cw(1'b1, 1'b0, 4'h4, 2'b11, 1'b0, 3'h0), 4, 60);
    // same mask word unarmed is a plain read frame
    frame(16'h2440, 4, 60);
    `CHK(seq_mode, SEQ_IDLE)
    // power modes
    frame(cw(1'b1, 1'b0, 4'h4, 2'b10, 1'b0, 3'h0), 4, 60);
    `CHK(adc_power_on, 1'b0)
    `CHK(adc_ready, 1'b0)
    frame(cw(1'b1, 1'b0, 4'h4, 2'b00, 1'b0, 3'h0), 4, 60);
    `CHK(adc_bias_on, 1'b1)
    `CHK(adc_power_on, 1'b0)
    // long lead: wake completes before the conversion, then it sleeps
    frame(cw(1'b1, 1'b0, 4'h4, 2'b01, 1'b0, 3'h0), 4, 1500);
    `CHK(adc_power_on, 1'b0)
    `CHK(adc_bias_on, 1'b0)
    // wake from sleep: not ready early, ready after about 1 us
    fork
      frame(cw(1'b1, 1'b0, 4'h4, 2'b01, 1'b0, 3'h0), 4, 1500);
      begin
        #(900);
        `CHK(adc_ready, 1'b0)
        #(500);
        `CHK(adc_ready, 1'b1)
      end
    join
    frame(cw(1'b1, 1'b0, 4'h4, 2'b11, 1'b0, 3'h0), 4, 60);
    repeat (30) @(posedge clk);
    `CHK(adc_ready, 1'b1)
    test_done();
  end
endmodule // tb_top
